// ===== logic/svo_pkg.sv
// Shared constants and types of the stream-to-video output lock block
package svo_pkg;
    // Fields that must line up at field start before lock is reported
    localparam int LOCK_FIELDS = 4;
    // Free entries kept when ready falls; covers the one beat in flight
    localparam int AF_MARGIN   = 2;
    // Width of the consecutive-field counter
    localparam int FCNT_W      = 4;

    typedef enum logic [1:0] {
        SVO_ALIGN = 2'b00,
        SVO_WAIT  = 2'b01,
        SVO_TRACK = 2'b10,
        SVO_LOCK  = 2'b11
    } svo_state_t;
endpackage

// ===== logic/svo_fifo_if.sv
// Carrier between the lock logic and its clock-crossing FIFO
`timescale 1ns/100ps
interface svo_fifo_if #(parameter int W = 26);
    logic [W-1:0] wr_data;
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] rd_data;
    logic         rd_valid;
    logic         rd_ready;
    modport fifo (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid);
    modport user (output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid);
endinterface

// ===== logic/svo_fifo.sv
// Dual-clock FIFO with handshake pointer exchange and almost-full ready
`timescale 1ns/100ps
module svo_fifo import svo_pkg::*; #(
    parameter int W     = 26,
    parameter int DEPTH = 32
) (
    input  wire logic    clk,
    input  wire logic    resetn,
    input  wire logic    pix_clk,
    input  wire logic    pix_rstn,
    svo_fifo_if.fifo     f
);
    localparam int PW     = $clog2(DEPTH);
    localparam int AF_LVL = DEPTH - AF_MARGIN;
    localparam int HS_MAX = 40;

    generate
        if (DEPTH < 8 || (1 << PW) != DEPTH)
            $error("svo_fifo: DEPTH must be a power of two, at least 8");
    endgenerate

    logic [W-1:0]  mem [DEPTH];
    // ------------------------------------------------------------
    // Write side (stream clock)
    // ------------------------------------------------------------
    logic [PW:0] wr_ptr, next_wr_ptr, w_snap, next_w_snap, rd_seen, next_rd_seen;
    logic [PW:0] wr_lvl, next_lvl;
    logic        w_req, next_w_req, r_ack, rdy, next_rdy, wr_en;
    logic        w_ack_s1, w_ack_s2, r_req_s1, r_req_s2;
    logic [PW:0] rd_ptr, next_rd_ptr, r_snap, next_r_snap, w_seen, next_w_seen;
    logic        r_req, next_r_req, w_ack;
    logic        r_ack_s1, r_ack_s2, w_req_s1, w_req_s2, rd_en;

    assign f.wr_ready = rdy;
    assign wr_en      = f.wr_valid & rdy;
    assign wr_lvl     = wr_ptr - rd_seen;

    always_comb begin
        next_wr_ptr  = wr_ptr + {{PW{1'b0}}, wr_en};
        // Stale read pointer only overstates the level, which is safe
        next_lvl     = next_wr_ptr - rd_seen;
        next_rdy     = next_lvl < (PW+1)'(AF_LVL);
        next_w_snap  = w_snap;
        next_w_req   = w_req;
        if (w_ack_s2 == w_req) begin
            next_w_snap = wr_ptr;
            next_w_req  = ~w_req;
        end
        next_rd_seen = (r_req_s2 != r_ack) ? r_snap : rd_seen;
    end

    always_ff @(posedge clk) begin
        w_ack_s1 <= w_ack;
        w_ack_s2 <= w_ack_s1;
        r_req_s1 <= r_req;
        r_req_s2 <= r_req_s1;
        if (!resetn) begin
            wr_ptr  <= '0;
            w_snap  <= '0;
            w_req   <= 1'b0;
            rd_seen <= '0;
            r_ack   <= 1'b0;
            rdy     <= 1'b0;
        end else begin
            wr_ptr  <= next_wr_ptr;
            w_snap  <= next_w_snap;
            w_req   <= next_w_req;
            rd_seen <= next_rd_seen;
            r_ack   <= r_req_s2;
            rdy     <= next_rdy;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en)
            mem[wr_ptr[PW-1:0]] <= f.wr_data;
    end

    // ------------------------------------------------------------
    // Read side (pixel clock)
    // ------------------------------------------------------------
    assign f.rd_valid = rd_ptr != w_seen;
    assign f.rd_data  = mem[rd_ptr[PW-1:0]];
    assign rd_en      = f.rd_valid & f.rd_ready;

    always_comb begin
        next_rd_ptr = rd_ptr + {{PW{1'b0}}, rd_en};
        next_r_snap = r_snap;
        next_r_req  = r_req;
        if (r_ack_s2 == r_req) begin
            next_r_snap = rd_ptr;
            next_r_req  = ~r_req;
        end
        next_w_seen = (w_req_s2 != w_ack) ? w_snap : w_seen;
    end

    always_ff @(posedge pix_clk) begin
        r_ack_s1 <= r_ack;
        r_ack_s2 <= r_ack_s1;
        w_req_s1 <= w_req;
        w_req_s2 <= w_req_s1;
        if (!pix_rstn) begin
            rd_ptr <= '0;
            r_snap <= '0;
            r_req  <= 1'b0;
            w_seen <= '0;
            w_ack  <= 1'b0;
        end else begin
            rd_ptr <= next_rd_ptr;
            r_snap <= next_r_snap;
            r_req  <= next_r_req;
            w_seen <= next_w_seen;
            w_ack  <= w_req_s2;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_READY_AF: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) |-> rdy == (($past(wr_lvl) + (PW+1)'($past(wr_en))) < (PW+1)'(AF_LVL)))
        else $error("ready does not follow almost-full level");
    AST_NO_OVERRUN: assert property (@(posedge clk) disable iff (!resetn)
        wr_en |-> wr_lvl < (PW+1)'(DEPTH))
        else $error("write accepted into full fifo");
    AST_HS_RETURN: assert property (@(posedge clk) disable iff (!resetn)
        (w_req != w_ack_s2) |-> ##[1:HS_MAX] (w_req == w_ack_s2))
        else $error("pointer handshake did not return");
endmodule

// ===== logic/svo_lock.sv
// Stream-to-video output: flow control, field lock and timing stall
// Operation
// - Stream ready falls at FIFO almost-full and is held low in reset; high otherwise.
// - Video data and timing outputs stay low until lock is shown.
// - After lock, outputs start at the next field start only.
// - Master mode: generator free-runs; slave mode: device stalls it while tracking and while locked.
// - Clock-enable to generator drops to stall it when output must lag.
// - Data crosses clock domains via FIFO with handshaked pointer exchange.
`timescale 1ns/100ps
module svo_lock import svo_pkg::*; #(
    parameter int DATA_W     = 24,
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              pix_clk,
    input  wire logic              slave_mode,
    input  wire logic [DATA_W-1:0] s_tdata,
    input  wire logic              s_tvalid,
    input  wire logic              s_tuser,
    input  wire logic              s_tlast,
    output logic                   s_tready,
    input  wire logic              vtg_vsync,
    input  wire logic              vtg_hsync,
    input  wire logic              vtg_vblank,
    input  wire logic              vtg_hblank,
    input  wire logic              vtg_active,
    output logic                   vtg_ce,
    output logic [DATA_W-1:0]      vid_data,
    output logic                   vid_vsync,
    output logic                   vid_hsync,
    output logic                   vid_vblank,
    output logic                   vid_hblank,
    output logic                   vid_active,
    output logic                   locked
);
    localparam int FW = DATA_W + 2;

    generate
        if (DATA_W < 8 || DATA_W > 256)
            $error("svo_lock: DATA_W must be 8 to 256");
        if (LOCK_FIELDS < 1 || LOCK_FIELDS >= (1 << FCNT_W))
            $error("svo_lock: LOCK_FIELDS out of counter range");
    endgenerate

    // ------------------------------------------------------------
    // Clock crossing FIFO
    // ------------------------------------------------------------
    logic rst_s1, rst_s2, pix_rstn;
    logic mode_s1, slave;

    svo_fifo_if #(.W(FW)) fq ();

    assign fq.wr_data  = {s_tuser, s_tlast, s_tdata};
    assign fq.wr_valid = s_tvalid;
    assign s_tready    = fq.wr_ready;

    svo_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .resetn   (resetn),
        .pix_clk  (pix_clk),
        .pix_rstn (pix_rstn),
        .f        (fq.fifo)
    );

    // ------------------------------------------------------------
    // Pixel-domain reset and mode synchronisers
    // ------------------------------------------------------------
    // Reset leaves the pixel domain two pixel edges late; the pixel
    // clock must run while resetn is low for the reset to land.
    always_ff @(posedge pix_clk) begin
        rst_s1  <= resetn;
        rst_s2  <= rst_s1;
        mode_s1 <= slave_mode;
        slave   <= mode_s1;
    end
    assign pix_rstn = rst_s2;

    // ------------------------------------------------------------
    // Two-entry buffer at the FIFO read port
    // ------------------------------------------------------------
    logic [FW-1:0] b0, b1, next_b0, next_b1;
    logic [1:0]    bcnt, next_bcnt;
    logic          push, pop, head_valid, head_sof;

    assign fq.rd_ready = bcnt != 2'h2;
    assign push        = fq.rd_valid & fq.rd_ready;
    assign head_valid  = bcnt != 2'h0;
    assign head_sof    = head_valid & b0[FW-1];

    always_comb begin
        next_b0   = b0;
        next_b1   = b1;
        next_bcnt = bcnt;
        unique case ({push, pop})
            2'b10: begin
                if (bcnt == 2'h0)
                    next_b0 = fq.rd_data;
                else
                    next_b1 = fq.rd_data;
                next_bcnt = bcnt + 2'h1;
            end
            2'b01: begin
                next_b0   = b1;
                next_bcnt = bcnt - 2'h1;
            end
            2'b11: begin
                if (bcnt == 2'h1) begin
                    next_b0 = fq.rd_data;
                end else begin
                    next_b0 = b1;
                    next_b1 = fq.rd_data;
                end
            end
            2'b00: ;
        endcase
    end

    always_ff @(posedge pix_clk) begin
        b0 <= next_b0;
        b1 <= next_b1;
        if (!pix_rstn)
            bcnt <= 2'h0;
        else
            bcnt <= next_bcnt;
    end

    // ------------------------------------------------------------
    // Field lock state machine
    // ------------------------------------------------------------
    svo_state_t          st, next_st;
    logic [FCNT_W-1:0]   fcnt, next_fcnt;
    logic                armed, next_armed, out_en, next_out_en;
    logic                next_ce, ce_d, vs_q, vs_rise, fresh, lock_start;

    assign vs_rise    = vtg_vsync & ~vs_q;
    // Generator timing only advanced if ce was high one cycle back
    assign fresh      = ce_d;
    assign lock_start = st == SVO_LOCK && vs_rise && !vtg_active;

    always_comb begin
        next_st     = st;
        next_fcnt   = fcnt;
        next_armed  = armed;
        next_out_en = out_en;
        next_ce     = 1'b1;
        pop         = 1'b0;
        unique case (st)
            SVO_ALIGN: begin
                // Discard stream data up to the next start of frame
                pop = head_valid & ~head_sof;
                if (head_sof)
                    next_st = SVO_WAIT;
            end
            SVO_WAIT: begin
                if (vs_rise) begin
                    next_st    = SVO_TRACK;
                    next_armed = 1'b1;
                    next_fcnt  = '0;
                end
            end
            SVO_TRACK, SVO_LOCK: begin
                if (vs_rise)
                    next_armed = 1'b1;
                if (st == SVO_LOCK && vs_rise)
                    next_out_en = 1'b1;
                if (fresh && vtg_active) begin
                    // First active pixel must meet start of frame, no other may
                    if (head_valid && (armed == head_sof)) begin
                        pop = 1'b1;
                        if (armed) begin
                            next_armed = 1'b0;
                            if (fcnt == FCNT_W'(LOCK_FIELDS - 1))
                                next_st = SVO_LOCK;
                            else
                                next_fcnt = fcnt + FCNT_W'(1);
                        end
                    end else begin
                        next_st = SVO_ALIGN;
                    end
                end
                // Slave: hold the generator until stream data reaches field start
                if (slave && armed && !head_sof)
                    next_ce = 1'b0;
            end
        endcase
        if (next_st == SVO_ALIGN)
            next_armed = 1'b0;
        if (next_st != SVO_LOCK)
            next_out_en = 1'b0;
    end

    always_ff @(posedge pix_clk) begin
        if (!pix_rstn) begin
            st     <= SVO_ALIGN;
            fcnt   <= '0;
            armed  <= 1'b0;
            out_en <= 1'b0;
            vtg_ce <= 1'b1;
            ce_d   <= 1'b1;
            vs_q   <= 1'b0;
        end else begin
            st     <= next_st;
            fcnt   <= next_fcnt;
            armed  <= next_armed;
            out_en <= next_out_en;
            vtg_ce <= next_ce;
            ce_d   <= vtg_ce;
            vs_q   <= vtg_vsync;
        end
    end

    // ------------------------------------------------------------
    // Registered video outputs
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_vdata;
    logic [4:0]        next_tim;

    always_comb begin
        next_tim   = {vtg_vsync, vtg_hsync, vtg_vblank, vtg_hblank, vtg_active} & {5{next_out_en}};
        next_vdata = '0;
        if (next_out_en && vtg_active && head_valid)
            next_vdata = b0[DATA_W-1:0];
    end

    always_ff @(posedge pix_clk) begin
        if (!pix_rstn) begin
            vid_data   <= '0;
            vid_vsync  <= 1'b0;
            vid_hsync  <= 1'b0;
            vid_vblank <= 1'b0;
            vid_hblank <= 1'b0;
            vid_active <= 1'b0;
            locked     <= 1'b0;
        end else begin
            vid_data   <= next_vdata;
            vid_vsync  <= next_tim[4];
            vid_hsync  <= next_tim[3];
            vid_vblank <= next_tim[2];
            vid_hblank <= next_tim[1];
            vid_active <= next_tim[0];
            locked     <= next_st == SVO_LOCK;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_start_locked;
        lock_start ##1 out_en;
    endsequence

    AST_QUIET_UNLOCKED: assert property (@(posedge pix_clk) disable iff (!pix_rstn)
        !locked |-> !vid_active && !vid_vsync && !vid_hsync && !vid_vblank && !vid_hblank && vid_data == '0)
        else $error("video output active while unlocked");
    AST_FIELD_START: assert property (@(posedge pix_clk) disable iff (!pix_rstn)
        $rose(out_en) |-> $past(lock_start))
        else $error("output enabled away from field start");
    AST_FIELD_OUT: assert property (@(posedge pix_clk) disable iff (!pix_rstn)
        lock_start |-> s_start_locked and ##1 vid_vsync)
        else $error("locked field start did not reach outputs");
    AST_CE_STALL: assert property (@(posedge pix_clk) disable iff (!pix_rstn)
        slave && armed && !head_sof && (st == SVO_TRACK || st == SVO_LOCK) |=> !vtg_ce)
        else $error("generator not stalled while waiting for stream");
    AST_MASTER_FREE: assert property (@(posedge pix_clk) disable iff (!pix_rstn)
        !slave |=> vtg_ce)
        else $error("generator stalled in master mode");
endmodule

// ===== sim/svo_partner.sv
// Stream source and external timing generator models for the output lock block
`timescale 1ns/100ps
module svo_partner #(
    parameter int DATA_W = 24
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         pix_clk,
    input  wire logic         feed_en,
    output logic [DATA_W-1:0] s_tdata,
    output logic              s_tvalid,
    output logic              s_tuser,
    output logic              s_tlast,
    input  wire logic         s_tready,
    input  wire logic         vtg_ce,
    output logic              vtg_vsync,
    output logic              vtg_hsync,
    output logic              vtg_vblank,
    output logic              vtg_hblank,
    output logic              vtg_active
);
    logic [3:0] idx = 4'h0;
    logic [7:0] frm = 8'h00;
    logic       took = 1'b0;
    logic       ce_q = 1'b1;
    int         hc = 0;
    int         vc = 0;

    initial begin
        s_tdata  = '0;
        s_tvalid = 1'b0;
        s_tuser  = 1'b0;
        s_tlast  = 1'b0;
    end

    // ----------------------------------------
    // Stream source: 12 beats a frame
    // ----------------------------------------
    always @(posedge clk) took <= s_tvalid && s_tready;

    // Pauses only at a frame boundary; an idle bus shows inverted data
    always @(negedge clk) begin
        if (!resetn) begin
            s_tvalid = 1'b0;
            idx      = 4'h0;
        end else if (!s_tvalid || took) begin
            if (idx == 4'h0 && !feed_en) begin
                s_tvalid = 1'b0;
                s_tdata  = ~s_tdata;
            end else begin
                s_tvalid = 1'b1;
                s_tdata  = DATA_W'({frm, 8'h3C, 4'h0, idx});
                s_tuser  = (idx == 4'h0);
                s_tlast  = (idx[1:0] == 2'h3);
                idx      = (idx == 4'hB) ? 4'h0 : idx + 4'h1;
                if (idx == 4'h0) frm = frm + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Timing generator: 8 x 5 raster
    // ----------------------------------------
    always @(posedge pix_clk) ce_q <= vtg_ce;

    // Advances only when enabled; holds every output while stalled
    always @(negedge pix_clk) begin
        if (!resetn) begin
            hc = 0;
            vc = 0;
        end else if (ce_q) begin
            hc = (hc == 7) ? 0 : hc + 1;
            if (hc == 0) vc = (vc == 4) ? 0 : vc + 1;
        end
        vtg_vsync  = (vc == 0);
        vtg_vblank = (vc < 2);
        vtg_hblank = (hc >= 4);
        vtg_hsync  = (hc == 5 || hc == 6);
        vtg_active = (vc >= 2) && (hc < 4);
    end
endmodule

// ===== sim/tb.sv
// Self-checking testbench of the stream-to-video output lock block
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0;
    logic        pix_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        slave_mode = 1'b0;
    logic        feed_en = 1'b0;
    logic [23:0] s_tdata;
    logic        s_tvalid, s_tuser, s_tlast, s_tready;
    logic        vtg_vsync, vtg_hsync, vtg_vblank, vtg_hblank, vtg_active, vtg_ce;
    logic [23:0] vid_data;
    logic        vid_vsync, vid_hsync, vid_vblank, vid_hblank, vid_active, locked;
    logic [4:0]  vq = 5'h00;
    logic [4:0]  vo;
    logic        lk_prev = 1'b0, out_on = 1'b0, ce_low = 1'b0, lock_fell = 1'b0;
    logic [3:0]  exp_idx = 4'h0;
    int          fail_count = 0, checks_done = 0, act_cnt = 0, taken = 0, pix_cnt = 0, cyc = 0;

    initial forever #2.5 clk = ~clk;
    initial begin
        #3;
        forever #16 pix_clk = ~pix_clk;
    end

    svo_lock #(.DATA_W(24), .FIFO_DEPTH(32)) svo_lock_inst (.clk(clk), .resetn(resetn), .pix_clk(pix_clk),
        .slave_mode(slave_mode), .s_tdata(s_tdata), .s_tvalid(s_tvalid), .s_tuser(s_tuser), .s_tlast(s_tlast),
        .s_tready(s_tready), .vtg_vsync(vtg_vsync), .vtg_hsync(vtg_hsync), .vtg_vblank(vtg_vblank),
        .vtg_hblank(vtg_hblank), .vtg_active(vtg_active), .vtg_ce(vtg_ce), .vid_data(vid_data),
        .vid_vsync(vid_vsync), .vid_hsync(vid_hsync), .vid_vblank(vid_vblank), .vid_hblank(vid_hblank),
        .vid_active(vid_active), .locked(locked));

    svo_partner #(.DATA_W(24)) svo_partner_inst (.clk(clk), .resetn(resetn), .pix_clk(pix_clk),
        .feed_en(feed_en), .s_tdata(s_tdata), .s_tvalid(s_tvalid), .s_tuser(s_tuser), .s_tlast(s_tlast),
        .s_tready(s_tready), .vtg_ce(vtg_ce), .vtg_vsync(vtg_vsync), .vtg_hsync(vtg_hsync),
        .vtg_vblank(vtg_vblank), .vtg_hblank(vtg_hblank), .vtg_active(vtg_active));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (s_tvalid && s_tready) taken <= taken + 1;
        if (cyc == 40000) begin
            fail_count++;
            close_out();
        end
    end

    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    always @(posedge pix_clk) begin
        pix_cnt <= pix_cnt + 1;
        vq      <= {vtg_vsync, vtg_hsync, vtg_vblank, vtg_hblank, vtg_active};
        if (resetn && vtg_ce === 1'b0) ce_low <= 1'b1;
    end

    // One cycle of slack where lock drops, since both are registered
    always @(negedge pix_clk) begin
        vo = {vid_vsync, vid_hsync, vid_vblank, vid_hblank, vid_active};
        if (!resetn) begin
            out_on = 1'b0;
        end else begin
            if (locked !== 1'b1) begin
                if (!lk_prev) chkv({vid_data, vo}, 32'h0);
                lock_fell = lock_fell | lk_prev;
                out_on    = 1'b0;
            end else if (!out_on && vo != 5'h00) begin
                chk1(vid_vsync, 1'b1);
                out_on  = 1'b1;
                exp_idx = 4'h0;
            end
            if (out_on) begin
                chkv(vo, vq);
                if (vid_active) begin
                    chkv(vid_data[15:0], {8'h3C, 4'h0, exp_idx});
                    exp_idx = (exp_idx == 4'hB) ? 4'h0 : exp_idx + 4'h1;
                    act_cnt++;
                end
            end
        end
        lk_prev = (locked === 1'b1);
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic do_reset(input logic slave);
        @(negedge clk);
        resetn     = 1'b0;
        slave_mode = slave;
        feed_en    = 1'b0;
        repeat (3) @(posedge clk);
        repeat (3) @(posedge pix_clk);
        @(negedge clk);
        chkv({s_tready, vtg_ce, locked}, 32'h2);
        chkv({vid_data, vid_vsync, vid_hsync, vid_vblank, vid_hblank, vid_active}, 32'h0);
        resetn = 1'b1;
        ce_low = 1'b0;
    endtask

    task automatic wait_lock(input logic lvl, input int max_clk);
        for (int i = 0; i < max_clk && locked !== lvl; i++) @(negedge clk);
    endtask

    task automatic t_backpressure();
        int p0;
        p0      = pix_cnt;
        feed_en = 1'b1;
        for (int i = 0; i < 400 && (s_tready !== 1'b0 || taken == 0); i++) @(negedge clk);
        chk1(taken >= 30, 1'b1);
        chk1(taken <= 32 + pix_cnt - p0, 1'b1);
    endtask

    task automatic t_window(input int n_exp);
        int a0;
        repeat (80) @(posedge pix_clk);
        a0 = act_cnt;
        repeat (120) @(posedge pix_clk);
        chkv(act_cnt - a0, n_exp);
    endtask

    task automatic t_master_lock();
        wait_lock(1'b1, 6000);
        chk1(locked, 1'b1);
        t_window(36);
        chk1(ce_low, 1'b0);
    endtask

    // Starved stream in master mode must drop lock, then relock
    task automatic t_master_underflow();
        @(negedge clk);
        feed_en = 1'b0;
        wait_lock(1'b0, 2000);
        chk1(locked, 1'b0);
        feed_en = 1'b1;
        wait_lock(1'b1, 6000);
        t_window(36);
    endtask

    task automatic t_slave_stall();
        do_reset(1'b1);
        feed_en = 1'b1;
        wait_lock(1'b1, 6000);
        chk1(locked, 1'b1);
        repeat (80) @(posedge pix_clk);
        @(negedge clk);
        feed_en   = 1'b0;
        ce_low    = 1'b0;
        lock_fell = 1'b0;
        repeat (200) @(posedge pix_clk);
        @(negedge clk);
        chk1(vtg_ce, 1'b0);
        chk1(ce_low, 1'b1);
        feed_en = 1'b1;
        t_window(36);
        chk1(lock_fell, 1'b0);
        chk1(vtg_ce, 1'b1);
    endtask

    initial begin
        do_reset(1'b0);
        t_backpressure();
        t_master_lock();
        t_master_underflow();
        t_slave_stall();
        close_out();
    end
endmodule
